// ===== rsdf_pkg.sv
package rsdf_pkg;

   // ==========================================================
   // Register byte offsets
   // ==========================================================
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_IRQCFG   = 8'h04;
   localparam logic [7:0] OFS_FIFOSTAT = 8'h08;
   localparam logic [7:0] OFS_FIFOCFG  = 8'h0C;
   localparam logic [7:0] OFS_STRTHR   = 8'h10;
   localparam logic [7:0] OFS_STRVAL   = 8'h14;
   localparam logic [7:0] OFS_SYNCPAT  = 8'h18;
   localparam logic [7:0] OFS_FIFODATA = 8'h1C;

   // ==========================================================
   // Field positions
   // ==========================================================
   localparam int CTRL_DATA_MODE  = 0;
   localparam int CTRL_RECOG_EN   = 1;
   localparam int CTRL_CLKREC_DIS = 2;
   localparam int CTRL_PATSZ_LO   = 3;
   localparam int CTRL_PTOL_LO    = 5;
   localparam int IRQ_SRCA_LO     = 0;
   localparam int IRQ_SRCB_LO     = 2;
   localparam int IRQ_STR_EN      = 4;
   localparam int IRQ_FILL_COND   = 5;
   localparam int IRQ_START_DET   = 6;
   localparam int IRQ_SIG_DET     = 7;
   localparam int FST_OVERFLOW    = 0;
   localparam int FST_NOT_EMPTY   = 1;
   localparam int FST_FULL        = 2;
   localparam int FST_THRESH      = 3;
   localparam int FST_COUNT_LO    = 8;
   localparam int FCFG_DEPTH_LO   = 0;
   localparam int FCFG_THRESH_LO  = 2;

   // ==========================================================
   // Reset values and fixed figures
   // ==========================================================
   localparam logic [1:0]  DEPTH_SEL_RESET  = 2'h3;
   localparam logic [5:0]  FIFO_THR_RESET   = 6'h00;
   localparam logic [7:0]  STR_THR_RESET    = 8'h00;
   localparam logic [31:0] SYNC_PAT_RESET   = 32'h00000000;
   localparam logic [3:0]  COARSE_PER_AVG   = 4'hF;
   localparam logic [2:0]  BITS_PER_BYTE    = 3'h7;

endpackage : rsdf_pkg

// ===== rsdf_rx_core.sv
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps

module rsdf_rx_core
   import rsdf_pkg::*;
#(
   parameter int FIFO_DEPTH = 64
) (
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        recoveredBitClock,
   input  wire logic        demodData,
   input  wire logic [4:0]  coarseStrength,
   input  wire logic        coarseStrobe,
   output logic             patternDetect,
   output logic             serialDataOut,
   output logic             bitClockOut,
   output logic             interruptPinA,
   output logic             interruptPinB
);

   localparam int PW = $clog2(FIFO_DEPTH);
   typedef struct packed {
      logic [FIFO_DEPTH-1:0][7:0] mem;
      logic [PW-1:0]  wrPtr;
      logic [PW-1:0]  rdPtr;
      logic [6:0]     count;
      logic           dclkMeta;
      logic           dclkSync;
      logic           dclkLast;
      logic           dataMeta;
      logic           dataSync;
      logic           strbMeta;
      logic           strbSync;
      logic           strbLast;
      logic [4:0]     coarseMeta;
      logic [4:0]     coarseSync;
      logic [8:0]     accum;
      logic [3:0]     sampleCnt;
      logic [7:0]     strength;
      logic           dataMode;
      logic           recogEn;
      logic           clkRecDis;
      logic [1:0]     patSize;
      logic [1:0]     patTol;
      logic [1:0]     srcA;
      logic [1:0]     srcB;
      logic           strIrqEn;
      logic           fillCond;
      logic           startDet;
      logic           sigDetect;
      logic           overflow;
      logic [1:0]     depthSel;
      logic [5:0]     fifoThr;
      logic [7:0]     strThr;
      logic [31:0]    syncPattern;
      logic [31:0]    shiftReg;
      logic [7:0]     byteAsm;
      logic [2:0]     bitCnt;
      logic           patternOut;
      logic           byteWritten;
      logic           dataOut;
      logic           clkOut;
      logic           pinA;
      logic           pinB;
      logic [31:0]    rdData;
      logic           popArm;
   } rsdf_state_t;
   rsdf_state_t r;
   rsdf_state_t n;

   // ==========================================================
   // Helpers
   // ==========================================================
   function automatic logic [5:0] rsdf_ones(input logic [31:0] v);
      logic [5:0] c;
      c = 6'h00;
      for (int i = 0; i < 32; i++) begin
         c = c + {5'h00, v[i]};
      end
      return c;
   endfunction : rsdf_ones
   function automatic logic [31:0] rsdf_size_mask(input logic [1:0] sz);
      logic [31:0] m;
      unique case (sz)
         2'h0: m = 32'h000000FF;
         2'h1: m = 32'h0000FFFF;
         2'h2: m = 32'h00FFFFFF;
         2'h3: m = 32'hFFFFFFFF;
      endcase
      return m;
   endfunction : rsdf_size_mask
   function automatic logic [6:0] rsdf_depth(input logic [1:0] sel);
      return {sel, 4'h0} + 7'h10;
   endfunction : rsdf_depth

   // ==========================================================
   // Combinational next state
   // ==========================================================
   logic        recoveryOn;
   logic        bitTick;
   logic        recogOn;
   logic [31:0] shiftNext;
   logic [5:0]  errs;
   logic        hit;
   logic        push;
   logic        pop;
   logic        flush;
   logic        stopFill;
   logic        apbWr;
   logic        apbRd;
   logic        mapped;
   logic [6:0]  depthBytes;
   logic        fullNow;
   logic [10:0] avgProd;
   logic [8:0]  accSum;
   always_comb begin
      n = r;
      n.byteWritten = 1'b0;
      push = 1'b0;
      pop = 1'b0;
      flush = 1'b0;
      stopFill = 1'b0;
      avgProd = 11'h000;
      accSum = 9'h000;
      // Two-stage synchronisers; the first stage never feeds logic, and bit clock and strobe add a third stage for edge detection
      n.dclkMeta   = recoveredBitClock;
      n.dclkSync   = r.dclkMeta;
      n.dclkLast   = r.dclkSync;
      n.dataMeta   = demodData;
      n.dataSync   = r.dataMeta;
      n.strbMeta   = coarseStrobe;
      n.strbSync   = r.strbMeta;
      n.strbLast   = r.strbSync;
      n.coarseMeta = coarseStrength;
      n.coarseSync = r.coarseMeta;
      recoveryOn = !r.clkRecDis || r.dataMode;
      bitTick    = r.dclkSync && !r.dclkLast && recoveryOn;
      recogOn    = (r.recogEn || r.dataMode) && recoveryOn;
      shiftNext  = {r.shiftReg[30:0], r.dataSync};
      errs       = rsdf_ones((shiftNext ^ r.syncPattern) & rsdf_size_mask(r.patSize));
      hit        = errs <= {4'h0, r.patTol};
      depthBytes = rsdf_depth(r.depthSel);
      fullNow    = r.count >= depthBytes;
      apbWr  = psel && penable && pwrite;
      apbRd  = psel && penable && !pwrite;
      mapped = (paddr[1:0] == 2'h0) && (paddr <= OFS_FIFODATA);
      // ==========================================================
      // Bit stream: pattern match and byte assembly
      // ==========================================================
      if (bitTick) begin
         n.shiftReg = shiftNext;
         if (!r.dataMode) begin
            n.patternOut = recogOn && hit;
            n.dataOut = r.dataSync;
         end else begin
            n.patternOut = 1'b0;
            if (!r.startDet) begin
               // Preamble and pattern bits never reach the assembler
               if (!r.fillCond && hit) begin
                  n.startDet = 1'b1;
                  n.patternOut = 1'b1;
                  n.bitCnt = 3'h0;
               end
            end else begin
               n.byteAsm = {r.byteAsm[6:0], r.dataSync};
               n.bitCnt = r.bitCnt + 3'h1;
               if (r.bitCnt == BITS_PER_BYTE) begin
                  if (!fullNow) begin
                     push = 1'b1;
                  end else begin
                     n.overflow = 1'b1;
                  end
               end
            end
         end
      end else if (!recoveryOn) begin
         // Recovery off: raw demodulator straight through, no detect
         n.patternOut = 1'b0;
         n.dataOut = r.dataSync;
      end
      // ==========================================================
      // Signal strength averaging
      // ==========================================================
      if (r.strbSync && !r.strbLast) begin
         accSum = r.accum + {4'h0, r.coarseSync};
         n.sampleCnt = r.sampleCnt + 4'h1;
         if (r.sampleCnt == COARSE_PER_AVG) begin
            // Sum of 16 steps of 3 dB, rescaled to 0.5 dB: sum * 6 / 16
            avgProd = {2'h0, accSum} * 11'h003;
            n.strength = avgProd[10:3];
            n.accum = 9'h000;
         end else begin
            n.accum = accSum;
         end
      end
      // ==========================================================
      // Register writes
      // ==========================================================
      if (apbWr) begin
         unique case (paddr)
            OFS_CTRL: begin
               n.dataMode  = pwdata[CTRL_DATA_MODE];
               n.recogEn   = pwdata[CTRL_RECOG_EN];
               n.clkRecDis = pwdata[CTRL_CLKREC_DIS];
               n.patSize   = pwdata[CTRL_PATSZ_LO +: 2];
               n.patTol    = pwdata[CTRL_PTOL_LO +: 2];
            end
            OFS_IRQCFG: begin
               n.srcA     = pwdata[IRQ_SRCA_LO +: 2];
               n.srcB     = pwdata[IRQ_SRCB_LO +: 2];
               n.strIrqEn = pwdata[IRQ_STR_EN];
               n.fillCond = pwdata[IRQ_FILL_COND];
               if (pwdata[IRQ_SIG_DET]) begin
                  n.sigDetect = 1'b0;
               end
               if (pwdata[IRQ_START_DET]) begin
                  if (r.startDet) begin
                     stopFill = 1'b1;
                  end else if (pwdata[IRQ_FILL_COND]) begin
                     n.startDet = 1'b1;
                     n.bitCnt = 3'h0;
                  end
               end
            end
            OFS_FIFOSTAT: begin
               if (pwdata[FST_OVERFLOW]) begin
                  flush = 1'b1;
               end
            end
            OFS_FIFOCFG: begin
               n.depthSel = pwdata[FCFG_DEPTH_LO +: 2];
               n.fifoThr  = pwdata[FCFG_THRESH_LO +: 6];
            end
            OFS_STRTHR:  n.strThr = pwdata[7:0];
            OFS_SYNCPAT: n.syncPattern = pwdata;
            default: ;
         endcase
      end

      // Pop only what the setup cycle handed out, so a byte landing in between is kept
      if (apbRd && paddr == OFS_FIFODATA && r.popArm) begin
         pop = 1'b1;
      end
      // ==========================================================
      // FIFO storage
      // ==========================================================
      if (push) begin
         n.mem[r.wrPtr] = {r.byteAsm[6:0], r.dataSync};
         n.wrPtr = r.wrPtr + 1'b1;
         n.byteWritten = 1'b1;
      end
      if (pop) begin
         n.rdPtr = r.rdPtr + 1'b1;
      end
      n.count = r.count + {6'h00, push} - {6'h00, pop};
      if (stopFill) begin
         n.startDet = 1'b0;
         n.bitCnt = 3'h0;
      end
      if (flush) begin
         // Flush wins over a byte completing in the same cycle
         n.wrPtr = '0;
         n.rdPtr = '0;
         n.count = 7'h00;
         n.overflow = 1'b0;
         n.startDet = 1'b0;
         n.bitCnt = 3'h0;
         n.byteWritten = 1'b0;
      end
      // Hardware set wins over a clear in the same cycle
      if (r.strIrqEn && r.strength >= r.strThr) begin
         n.sigDetect = 1'b1;
      end

      // ==========================================================
      // Pins
      // ==========================================================
      n.clkOut = r.dclkSync && !r.dataMode && recoveryOn;
      if (r.dataMode) begin
         n.dataOut = 1'b0;
         unique case (r.srcA)
            2'h0: n.pinA = 1'b0;
            2'h1: n.pinA = r.byteWritten;
            2'h2: n.pinA = r.count != 7'h00;
            2'h3: n.pinA = r.patternOut;
         endcase
         unique case (r.srcB)
            2'h0: n.pinB = 1'b0;
            2'h1: n.pinB = fullNow;
            2'h2: n.pinB = r.sigDetect;
            2'h3: n.pinB = r.count >= {1'b0, r.fifoThr};
         endcase
      end else begin
         n.pinA = (r.srcA == 2'h1) ? r.sigDetect : r.patternOut;
         n.pinB = r.clkOut;
      end

      // ==========================================================
      // Read data, captured in the setup cycle
      // ==========================================================
      if (psel && !penable && !pwrite) begin
         n.rdData = 32'h00000000;
         n.popArm = (paddr == OFS_FIFODATA) && (r.count != 7'h00);
         unique case (paddr)
            OFS_CTRL: begin
               n.rdData[CTRL_DATA_MODE]     = r.dataMode;
               n.rdData[CTRL_RECOG_EN]      = r.recogEn;
               n.rdData[CTRL_CLKREC_DIS]    = r.clkRecDis;
               n.rdData[CTRL_PATSZ_LO +: 2] = r.patSize;
               n.rdData[CTRL_PTOL_LO +: 2]  = r.patTol;
            end
            OFS_IRQCFG: begin
               n.rdData[IRQ_SRCA_LO +: 2] = r.srcA;
               n.rdData[IRQ_SRCB_LO +: 2] = r.srcB;
               n.rdData[IRQ_STR_EN]       = r.strIrqEn;
               n.rdData[IRQ_FILL_COND]    = r.fillCond;
               n.rdData[IRQ_START_DET]    = r.startDet;
               n.rdData[IRQ_SIG_DET]      = r.sigDetect;
            end
            OFS_FIFOSTAT: begin
               n.rdData[FST_OVERFLOW]      = r.overflow;
               n.rdData[FST_NOT_EMPTY]     = r.count != 7'h00;
               n.rdData[FST_FULL]          = fullNow;
               n.rdData[FST_THRESH]        = r.count >= {1'b0, r.fifoThr};
               n.rdData[FST_COUNT_LO +: 7] = r.count;
            end
            OFS_FIFOCFG: begin
               n.rdData[FCFG_DEPTH_LO +: 2]  = r.depthSel;
               n.rdData[FCFG_THRESH_LO +: 6] = r.fifoThr;
            end
            OFS_STRTHR:   n.rdData[7:0] = r.strThr;
            OFS_STRVAL:   n.rdData[7:0] = r.strength;
            OFS_SYNCPAT:  n.rdData = r.syncPattern;
            OFS_FIFODATA: n.rdData[7:0] = (r.count != 7'h00) ? r.mem[r.rdPtr] : 8'h00;
            default: ;
         endcase
      end
   end

   // ==========================================================
   // State register
   // ==========================================================
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         r             <= '0;
         r.depthSel    <= DEPTH_SEL_RESET;
         r.fifoThr     <= FIFO_THR_RESET;
         r.strThr      <= STR_THR_RESET;
         r.syncPattern <= SYNC_PAT_RESET;
      end else begin
         r <= n;
      end
   end
   assign prdata        = r.rdData;
   assign pready        = psel && penable;
   assign pslverr       = psel && penable && !mapped;
   assign patternDetect = r.patternOut;
   assign serialDataOut = r.dataOut;
   assign bitClockOut   = r.clkOut;
   assign interruptPinA = r.pinA;
   assign interruptPinB = r.pinB;

endmodule : rsdf_rx_core

// ===== rsdf_rx_core_monitor.sv
`timescale 1ns/1ps

module rsdf_rx_core_monitor
   import rsdf_pkg::*;
(
   input logic        mclk,
   input logic        sys_rst,
   input logic [7:0]  paddr,
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic [31:0] pwdata,
   input logic [31:0] prdata,
   input logic        pready,
   input logic        pslverr,
   input logic        patternDetect,
   input logic        serialDataOut,
   input logic        bitClockOut,
   input logic        interruptPinA,
   input logic        interruptPinB
);
   // ==========================================================
   // Shadow of mode and pin selects
   // ==========================================================
   logic       modeReg;
   logic       recogReg;
   logic [1:0] selAReg;
   logic [1:0] selBReg;
   logic [1:0] settleReg;
   wire        wrEn     = psel && penable && pwrite && pready;
   wire        unmapped = (paddr[1:0] != 2'h0) || (paddr > OFS_FIFODATA);
   // Outputs lag a config write by a register stage, so wait before judging
   wire        quiet    = settleReg == 2'h3;
   wire        bufOn    = modeReg && quiet;

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         modeReg   <= 1'b0;
         recogReg  <= 1'b0;
         selAReg   <= 2'h0;
         selBReg   <= 2'h0;
         settleReg <= 2'h0;
      end else if (wrEn && paddr == OFS_CTRL) begin
         modeReg   <= pwdata[CTRL_DATA_MODE];
         recogReg  <= pwdata[CTRL_RECOG_EN];
         settleReg <= 2'h0;
      end else if (wrEn && paddr == OFS_IRQCFG) begin
         selAReg   <= pwdata[1:0];
         selBReg   <= pwdata[3:2];
         settleReg <= 2'h0;
      end else if (!quiet) begin
         settleReg <= settleReg + 2'h1;
      end
   end

   // ==========================================================
   // Properties
   // ==========================================================
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);

   sequence sAccess;
      psel && penable;
   endsequence
   sequence sBadRead;
      psel && penable && !pwrite && unmapped;
   endsequence
   sequence sMatchPulse;
      patternDetect [*4] ##[1:12] !patternDetect;
   endsequence

   AST_PREADY_HI: assert property (sAccess |-> pready)
      else $error("pready missing in access phase");
   AST_PREADY_LO: assert property (!(psel && penable) |-> !pready)
      else $error("pready outside access phase");
   AST_SLVERR_HI: assert property (sAccess ##0 unmapped |-> pslverr)
      else $error("no slave error on unmapped address");
   AST_SLVERR_LO: assert property (!unmapped || !penable |-> !pslverr)
      else $error("slave error without cause");
   AST_ERR_ZERO: assert property (sBadRead |-> prdata == 32'h00000000)
      else $error("unmapped read returned data");
   AST_BUF_QUIET: assert property (bufOn |-> !serialDataOut && !bitClockOut)
      else $error("serial pins active in buffered mode");
   AST_PINA_OFF: assert property (bufOn && selAReg == 2'h0 |-> !interruptPinA)
      else $error("pin A active with no source");
   AST_PINB_OFF: assert property (bufOn && selBReg == 2'h0 |-> !interruptPinB)
      else $error("pin B active with no source");
   AST_BYTE_PULSE: assert property (bufOn && selAReg == 2'h1 && $rose(interruptPinA) |=> !interruptPinA)
      else $error("byte written pulse longer than one cycle");
   AST_MATCH_PULSE: assert property (bufOn && $rose(patternDetect) |-> sMatchPulse)
      else $error("match pulse not one bit period");
   AST_RECOG_OFF: assert property (!modeReg && !recogReg && quiet |-> !patternDetect)
      else $error("pattern detect while recognition off");
endmodule : rsdf_rx_core_monitor

bind rsdf_rx_core rsdf_rx_core_monitor mon (.mclk(mclk), .sys_rst(sys_rst), .paddr(paddr),
   .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .patternDetect(patternDetect),
   .serialDataOut(serialDataOut), .bitClockOut(bitClockOut),
   .interruptPinA(interruptPinA), .interruptPinB(interruptPinB));

// ===== rsdf_radio_model.sv
`timescale 1ns/1ps

module rsdf_radio_model (
   output logic       recoveredBitClock,
   output logic       demodData,
   output logic [4:0] coarseStrength,
   output logic       coarseStrobe
);
   initial begin
      recoveredBitClock = 1'b0;
      demodData         = 1'b0;
      coarseStrength    = 5'h00;
      coarseStrobe      = 1'b0;
   end

   // Odd offset keeps bit edges off the system clock edges
   task sendByte(input logic [7:0] b);
      #7;
      for (int i = 7; i >= 0; i--) begin
         demodData = b[i];
         #100 recoveredBitClock = 1'b1;
         #100 recoveredBitClock = 1'b0;
      end
   endtask : sendByte

   // Clock stands still between frames; data shows no stale bit
   task endFrame;
      demodData = ~demodData;
   endtask : endFrame

   task sendStrength(input logic [4:0] v);
      coarseStrength = v;
      #50 coarseStrobe = 1'b1;
      #100 coarseStrobe = 1'b0;
      #50;
   endtask : sendStrength
endmodule : rsdf_radio_model

// ===== rsdf_tb.sv
`timescale 1ns/1ps

module tb;
   import rsdf_pkg::*;
   logic        mclk, sys_rst, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic        recoveredBitClock, demodData, coarseStrobe;
   logic [4:0]  coarseStrength, v;
   logic        patternDetect, serialDataOut, bitClockOut, interruptPinA, interruptPinB;
   logic [31:0] expQ[$];
   logic [7:0]  payload[$];
   int          failCount, testsRun, sum;

   rsdf_rx_core #(.FIFO_DEPTH(64)) uut (.mclk(mclk), .sys_rst(sys_rst), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .recoveredBitClock(recoveredBitClock),
      .demodData(demodData), .coarseStrength(coarseStrength), .coarseStrobe(coarseStrobe),
      .patternDetect(patternDetect), .serialDataOut(serialDataOut),
      .bitClockOut(bitClockOut), .interruptPinA(interruptPinA), .interruptPinB(interruptPinB));
   rsdf_radio_model radio (.recoveredBitClock(recoveredBitClock), .demodData(demodData),
      .coarseStrength(coarseStrength), .coarseStrobe(coarseStrobe));

   initial mclk = 1'b0;
   always #12.5 mclk = ~mclk;

   // ==========================================================
   // Checking and bus tasks
   // ==========================================================
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      testsRun++;
      if (seen !== exp) begin
         failCount++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task endOfTest;
      $display("comparisons %0d, mismatches %0d", testsRun, failCount);
      if (failCount == 0 && testsRun > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : endOfTest

   task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      {psel, penable} <= 2'b00;
      @(posedge mclk);
   endtask : apb

   task rd(input logic [7:0] a, input logic [31:0] e);
      expQ.push_back(e);
      apb(a, 1'b0, 32'h0);
   endtask : rd

   task pinChk(input logic [31:0] e, input logic b);
      @(negedge mclk);
      chk({31'h0, b ? interruptPinB : interruptPinA}, e);
      @(posedge mclk);
   endtask : pinChk

   // Expected order: pattern detect, serial data, bit clock
   task outChk(input logic [2:0] e);
      @(negedge mclk);
      chk({29'h0, patternDetect, serialDataOut, bitClockOut}, {29'h0, e});
      @(posedge mclk);
   endtask : outChk

   always @(posedge mclk) begin
      if (psel && penable && !pwrite && pready === 1'b1 && expQ.size() > 0)
         chk(prdata, expQ.pop_front());
   end

   // Whole run is well under 100 us; this only catches a hang
   initial begin
      #1_000_000;
      failCount++;
      endOfTest();
   end

   // ==========================================================
   // Tests
   // ==========================================================
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      sys_rst = 1'b1;
      void'($urandom(87));
      repeat (5) @(posedge mclk);
      sys_rst <= 1'b0;
      rd(OFS_CTRL, 32'h0);
      rd(OFS_FIFOCFG, {30'h0, DEPTH_SEL_RESET});
      rd(8'h20, 32'h0);
      $display("test reset done");
      apb(OFS_CTRL, 1'b1, 32'h01);
      apb(OFS_SYNCPAT, 1'b1, 32'hA5);
      apb(OFS_FIFOCFG, 1'b1, 32'h20);
      apb(OFS_IRQCFG, 1'b1, 32'h05);
      radio.sendByte(8'h55);
      radio.sendByte(8'h55);
      radio.sendByte(8'hA5);
      // One byte more than the depth, unread, to force a loss
      for (int i = 0; i < 17; i++) begin
         payload.push_back(8'($urandom));
         radio.sendByte(payload[i]);
      end
      radio.endFrame();
      repeat (10) @(posedge mclk);
      pinChk(32'h1, 1'b1);
      rd(OFS_FIFOSTAT, 32'h100F);
      rd(OFS_IRQCFG, 32'h45);
      for (int i = 0; i < 16; i++) rd(OFS_FIFODATA, {24'h0, payload[i]});
      rd(OFS_FIFOSTAT, 32'h01);
      apb(OFS_FIFOSTAT, 1'b1, 32'h01);
      rd(OFS_FIFOSTAT, 32'h00);
      rd(OFS_IRQCFG, 32'h05);
      rd(OFS_FIFODATA, 32'h0);
      $display("test buffered fill done");
      apb(OFS_CTRL, 1'b1, 32'h0);
      sum = 0;
      for (int i = 0; i < 16; i++) begin
         v = 5'($urandom_range(20, 1));
         sum += v;
         radio.sendStrength(v);
      end
      @(posedge mclk);
      apb(OFS_STRTHR, 1'b1, 32'(sum * 3 / 8));
      apb(OFS_IRQCFG, 1'b1, 32'h11);
      rd(OFS_STRVAL, 32'(sum * 3 / 8));
      rd(OFS_IRQCFG, 32'h91);
      pinChk(32'h1, 1'b0);
      apb(OFS_IRQCFG, 1'b1, 32'h91);
      rd(OFS_IRQCFG, 32'h91);
      apb(OFS_STRTHR, 1'b1, 32'(sum * 3 / 8 + 1));
      apb(OFS_IRQCFG, 1'b1, 32'h91);
      rd(OFS_IRQCFG, 32'h11);
      pinChk(32'h0, 1'b0);
      $display("test strength done");
      apb(OFS_IRQCFG, 1'b1, 32'h0);
      apb(OFS_SYNCPAT, 1'b1, 32'h3C);
      apb(OFS_CTRL, 1'b1, 32'h22);
      // One bit off the pattern, inside a tolerance of one
      radio.sendByte(8'h3D);
      repeat (8) @(posedge mclk);
      outChk(3'h6);
      pinChk(32'h1, 1'b0);
      apb(OFS_CTRL, 1'b1, 32'h26);
      outChk(3'h2);
      radio.endFrame();
      repeat (8) @(posedge mclk);
      outChk(3'h0);
      apb(OFS_CTRL, 1'b1, 32'h22);
      radio.sendByte(8'hF1);
      repeat (8) @(posedge mclk);
      outChk(3'h2);
      $display("test continuous done");
      apb(OFS_CTRL, 1'b1, 32'h01);
      apb(OFS_FIFOCFG, 1'b1, 32'h05);
      apb(OFS_IRQCFG, 1'b1, 32'h6C);
      payload[0] = 8'($urandom);
      radio.sendByte(payload[0]);
      repeat (8) @(posedge mclk);
      pinChk(32'h1, 1'b1);
      rd(OFS_FIFOSTAT, 32'h010A);
      rd(OFS_FIFOCFG, 32'h05);
      apb(OFS_IRQCFG, 1'b1, 32'h4C);
      rd(OFS_IRQCFG, 32'h0C);
      rd(OFS_FIFODATA, {24'h0, payload[0]});
      rd(OFS_FIFOSTAT, 32'h00);
      $display("test host fill done");
      endOfTest();
   end
endmodule : tb
